// File: i2cm_bus_model.sv
// Bus with pull-ups, an acknowledging slave and a line grabber
`timescale 1ns/100ps

module i2cm_bus_model (
  input  wire logic       scl_oe,
  input  wire logic       sda_oe,
  input  wire logic       sda_lo,
  output logic            scl,
  output logic            sda,
  output logic [7:0]      rx_byte
);
  logic [3:0] bit_cnt;
  logic       ack_drv;

  // Released lines float high; any party may pull data low, only the master pulls the clock
  assign scl = !scl_oe;
  assign sda = !(sda_oe || sda_lo || ack_drv);

  initial begin
    bit_cnt = 4'h0;
    ack_drv = 1'b0;
    rx_byte = 8'h00;
  end

  // Start or stop restarts framing, also after a lost arbitration
  always @(sda) begin
    if (scl) begin
      bit_cnt = 4'h0;
    end
  end

  // Data sampled on rising clock, MSB first
  always @(posedge scl) begin
    if (bit_cnt < 4'h8) begin
      rx_byte = {rx_byte[6:0], sda};
    end
    bit_cnt = bit_cnt + 4'h1;
  end

  // Acknowledge held over the ninth clock
  always @(negedge scl) begin
    ack_drv = (bit_cnt == 4'h8);
    if (bit_cnt == 4'h9) begin
      bit_cnt = 4'h0;
    end
  end
endmodule

// File: i2cm_pkg.sv
// Types of the master sequencer: states and register image
package i2cm_pkg;
  typedef enum logic [4:0] {
    I2CM_IDLE, I2CM_ST_CHK, I2CM_ST_HOLD, I2CM_ST_LOW,
    I2CM_RS_A, I2CM_RS_B, I2CM_RS_C, I2CM_RS_D, I2CM_RS_E,
    I2CM_TX_LOW, I2CM_TX_WAITH, I2CM_TX_HIGH,
    I2CM_AK_A, I2CM_AK_B, I2CM_AK_C,
    I2CM_SP_A, I2CM_SP_B, I2CM_SP_C, I2CM_SP_D, I2CM_SP_E
  } i2cm_state_t;

  typedef struct packed {
    i2cm_state_t st;
    logic [2:0]  scl_sy;
    logic [2:0]  sda_sy;
    logic        scl_l;
    logic        sda_l;
    logic        drv_scl;
    logic        drv_sda;
    logic [6:0]  cnt;
    logic        run;
    logic [6:0]  reload;
    logic [3:0]  bitn;
    logic [7:0]  shreg;
    logic [7:0]  buffer;
    logic        port_en;
    logic        start_en;
    logic        rstart_en;
    logic        stop_en;
    logic        ack_en;
    logic        ack_data;
    logic        int_en;
    logic        buf_full;
    logic        write_collision_flag;
    logic        bcol;
    logic        event_flag;
    logic        start_seen;
    logic        stop_seen;
    logic        ack_stat;
    logic [7:0]  rdata;
  } i2cm_state_s_t;
endpackage

// File: i2cm_regs.svh
// Offsets, field positions, reset values and widths of the sequencer
`ifndef I2CM_REGS_SVH
`define I2CM_REGS_SVH
`define I2CM_ADDR_W      4
`define I2CM_OFS_CTRL    4'h0
`define I2CM_OFS_STATUS  4'h4
`define I2CM_OFS_RELOAD  4'h8
`define I2CM_OFS_BUF     4'hC
// Control fields
`define I2CM_C_PORT_EN   0
`define I2CM_C_START     1
`define I2CM_C_RSTART    2
`define I2CM_C_STOP      3
`define I2CM_C_ACK       4
`define I2CM_C_ACK_DATA  5
`define I2CM_C_INT_EN    6
// Status fields, bits 1..5 clear on write of one
`define I2CM_S_BUF_FULL  0
`define I2CM_S_WRITE_COLLISION_FLAG      1
`define I2CM_S_BCOL      2
`define I2CM_S_EVENT     3
`define I2CM_S_START     4
`define I2CM_S_STOP      5
`define I2CM_S_BUSY      6
`define I2CM_S_ACK_STAT  7
`define I2CM_RELOAD_RST  7'h13
`define I2CM_LAST_BIT    4'h8
`endif

// File: i2cm_seq.sv
// I2C master sequencer: ack, stop, start, repeated start, arbitration
//
// Behaviour
// [R01] Ack enable pulls clock low and drives data with the ack data bit.
// [R02] Software picks ack or not-ack in the ack data bit beforehand.
// [R03] Ack: one period, release clock, when high one period, clock low, idle.
// [R04] Buffer write during ack sets write collision, buffer kept.
// [R05] Stop: data low, then count, release clock, period later release data.
// [R06] Data high with clock high sets stop seen; period later event, stop off.
// [R07] Buffer write during stop sets write collision, buffer kept.
// [R08] In sleep, a completed byte wakes the processor if interrupt enabled.
// [R09] Reset disables the port and ends any transfer.
// [R10] Start and stop seen flags clear on reset and while port disabled.
// [R11] Software takes the bus only after stop seen or when bus idle.
// [R12] Bus monitoring continues; a stop on the bus sets the event flag.
// [R13] Sending a one but reading data low flags bus collision and idles.
// [R14] Transfer collision halts, clears buffer full, releases lines.
// [R15] Sequence collision aborts, releases lines, clears sequence enables.
// [R16] After collision a buffer write restarts from the first data bit.
// [R17] Data or clock low when start begins aborts start with collision.
// [R18] Start: data high loads timer; clock low while data high collides.
// [R19] Data low early drives data early; then count, clock low at end.
// [R20] Repeated start: count, release clock, when high data low collides.
// [R21] Repeated start: data fall is fine, clock fall before data low collides.
// [R22] Both high at timeout: data low, count, clock low, complete.
// [R23] Bit timer counts reload down to zero and stops when idle.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "i2cm_regs.svh"

module i2cm_seq (
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  input  wire logic [`I2CM_ADDR_W-1:0]  reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [7:0]               reg_rdata,
  input  wire logic                     scl_in,
  output logic                          scl_out,
  output logic                          scl_oe,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe,
  input  wire logic                     sleep_mode,
  output logic                          wake_req
);

  i2cm_pkg::i2cm_state_s_t q;
  i2cm_pkg::i2cm_state_s_t n;
  logic tick;
  logic coll;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_buf;

  // Both lines are open drain: only ever pulled low
  assign scl_out   = 1'b0;
  assign sda_out   = 1'b0;
  assign scl_oe    = q.drv_scl;
  assign sda_oe    = q.drv_sda;
  assign reg_rdata = q.rdata;
  // Sleep wake from the event flag: finished byte, start, repeated start or stop; address match is not ours
  assign wake_req  = sleep_mode & q.int_en & q.event_flag; // [R08]
  assign tick      = q.run && (q.cnt == 7'h00);
  assign wr_ctrl   = reg_wr && (reg_addr == `I2CM_OFS_CTRL);
  assign wr_stat   = reg_wr && (reg_addr == `I2CM_OFS_STATUS);
  assign wr_buf    = reg_wr && (reg_addr == `I2CM_OFS_BUF);

  // Next state of the whole block
  always_comb begin
    n       = q;
    coll    = 1'b0;
    n.rdata = 8'h00;

    // Three stage sync; level moves once stages two and three agree
    n.scl_sy = {q.scl_sy[1:0], scl_in};
    n.sda_sy = {q.sda_sy[1:0], sda_in};
    if (q.scl_sy[1] == q.scl_sy[2]) begin
      n.scl_l = q.scl_sy[2];
    end
    if (q.sda_sy[1] == q.sda_sy[2]) begin
      n.sda_l = q.sda_sy[2];
    end

    // Bit timer counts down; holds at zero until reloaded or stopped
    if (q.run && q.cnt != 7'h00) begin
      n.cnt = q.cnt - 7'h01; // [R23]
    end

    // Register reads: data stand one cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        `I2CM_OFS_CTRL:   n.rdata = {1'b0, q.int_en, q.ack_data, q.ack_en,
                                     q.stop_en, q.rstart_en, q.start_en,
                                     q.port_en};
        `I2CM_OFS_STATUS: n.rdata = {q.ack_stat, q.st != i2cm_pkg::I2CM_IDLE,
                                     q.stop_seen, q.start_seen,
                                     q.event_flag, q.bcol, q.write_collision_flag,
                                     q.buf_full};
        `I2CM_OFS_RELOAD: n.rdata = {1'b0, q.reload};
        `I2CM_OFS_BUF:    n.rdata = q.buffer;
        default:          n.rdata = 8'h00;
      endcase
    end

    // Register writes; flags clear first so later sets win
    if (wr_ctrl) begin
      n.port_en  = reg_wdata[`I2CM_C_PORT_EN];
      n.ack_data = reg_wdata[`I2CM_C_ACK_DATA];
      n.int_en   = reg_wdata[`I2CM_C_INT_EN];
      // No queueing: sequence bits only taken while idle
      if (q.st == i2cm_pkg::I2CM_IDLE && q.port_en) begin
        n.start_en  = reg_wdata[`I2CM_C_START];
        n.rstart_en = reg_wdata[`I2CM_C_RSTART];
        n.stop_en   = reg_wdata[`I2CM_C_STOP];
        n.ack_en    = reg_wdata[`I2CM_C_ACK];
      end
    end
    if (wr_stat) begin
      if (reg_wdata[`I2CM_S_WRITE_COLLISION_FLAG]) n.write_collision_flag = 1'b0;
      if (reg_wdata[`I2CM_S_BCOL]) n.bcol = 1'b0;
      if (reg_wdata[`I2CM_S_EVENT]) n.event_flag = 1'b0;
      if (reg_wdata[`I2CM_S_START]) n.start_seen = 1'b0;
      if (reg_wdata[`I2CM_S_STOP]) n.stop_seen = 1'b0;
    end
    if (reg_addr == `I2CM_OFS_RELOAD && reg_wr) begin
      n.reload = reg_wdata[6:0];
    end
    // Buffer write: busy port refuses it and flags collision
    if (wr_buf) begin
      if (q.st != i2cm_pkg::I2CM_IDLE) begin
        n.write_collision_flag = 1'b1; // [R04] [R07]
      end else begin
        n.buffer = reg_wdata;
      end
    end

    // Bus monitor: start and stop seen on the filtered lines
    if (q.scl_l && n.scl_l && q.sda_l && !n.sda_l) begin
      n.start_seen = 1'b1;
      n.stop_seen  = 1'b0;
    end
    if (q.scl_l && n.scl_l && !q.sda_l && n.sda_l) begin
      n.stop_seen  = 1'b1; // [R06]
      n.start_seen = 1'b0;
      n.event_flag = 1'b1; // [R12]
    end

    // Sequencer
    unique case (q.st)
      i2cm_pkg::I2CM_IDLE: begin
        n.run = 1'b0; // [R23]
        if (q.start_en) begin
          n.st = i2cm_pkg::I2CM_ST_CHK;
        end else if (q.rstart_en) begin
          n.drv_scl = 1'b1;
          n.drv_sda = 1'b0;
          n.st      = i2cm_pkg::I2CM_RS_A;
        end else if (q.stop_en) begin
          n.drv_sda = 1'b1; // [R05]
          n.st      = i2cm_pkg::I2CM_SP_A;
        end else if (q.ack_en) begin
          n.drv_scl = 1'b1; // [R01]
          n.drv_sda = !q.ack_data; // [R01]
          n.cnt     = q.reload;
          n.run     = 1'b1;
          n.st      = i2cm_pkg::I2CM_AK_A;
        end else if (wr_buf && q.port_en) begin
          // Always from the first bit, even after a lost arbitration
          n.shreg    = reg_wdata; // [R16]
          n.bitn     = 4'h0; // [R16]
          n.buf_full = 1'b1;
          n.drv_scl  = 1'b1;
          n.cnt      = q.reload;
          n.run      = 1'b1;
          n.st       = i2cm_pkg::I2CM_TX_LOW;
        end
      end
      // Start: both lines must be high when it begins
      i2cm_pkg::I2CM_ST_CHK: begin
        if (!q.sda_l || !q.scl_l) begin
          coll = 1'b1; // [R17]
        end else begin
          n.cnt = q.reload; // [R18]
          n.run = 1'b1;
          n.st  = i2cm_pkg::I2CM_ST_HOLD;
        end
      end
      i2cm_pkg::I2CM_ST_HOLD: begin
        if (!q.scl_l && q.sda_l) begin
          coll = 1'b1; // [R18]
        end else if (!q.sda_l || tick) begin
          // Another master started first: follow it at once
          n.drv_sda = 1'b1; // [R19]
          n.cnt     = q.reload;
          n.st      = i2cm_pkg::I2CM_ST_LOW;
        end
      end
      i2cm_pkg::I2CM_ST_LOW: begin
        // Clock low from others is not a collision here
        if (tick) begin
          n.drv_scl    = 1'b1; // [R19]
          n.run        = 1'b0;
          n.start_en   = 1'b0;
          n.event_flag = 1'b1;
          n.st         = i2cm_pkg::I2CM_IDLE;
        end
      end
      // Repeated start: clock pulled low and data released together
      i2cm_pkg::I2CM_RS_A: begin
        if (!q.scl_l) begin
          n.cnt = q.reload;
          n.run = 1'b1;
          n.st  = i2cm_pkg::I2CM_RS_B;
        end
      end
      i2cm_pkg::I2CM_RS_B: begin
        if (tick && q.sda_l) begin
          n.drv_scl = 1'b0; // [R20]
          n.run     = 1'b0;
          n.st      = i2cm_pkg::I2CM_RS_C;
        end
      end
      i2cm_pkg::I2CM_RS_C: begin
        if (q.scl_l) begin
          if (!q.sda_l) begin
            coll = 1'b1; // [R20]
          end else begin
            n.cnt = q.reload; // [R21]
            n.run = 1'b1;
            n.st  = i2cm_pkg::I2CM_RS_D;
          end
        end
      end
      i2cm_pkg::I2CM_RS_D: begin
        // Data falling early is another start, not a collision
        if (!q.scl_l && q.sda_l) begin
          coll = 1'b1; // [R21]
        end else if (tick) begin
          n.drv_sda = 1'b1; // [R22]
          n.cnt     = q.reload;
          n.st      = i2cm_pkg::I2CM_RS_E;
        end
      end
      i2cm_pkg::I2CM_RS_E: begin
        if (tick) begin
          n.drv_scl    = 1'b1; // [R22]
          n.run        = 1'b0;
          n.rstart_en  = 1'b0;
          n.event_flag = 1'b1;
          n.st         = i2cm_pkg::I2CM_IDLE;
        end
      end
      // Transmit: eight data bits then the slave's ack bit
      i2cm_pkg::I2CM_TX_LOW: begin
        n.drv_sda = (q.bitn < `I2CM_LAST_BIT) ? !q.shreg[7] : 1'b0;
        if (tick) begin
          n.drv_scl = 1'b0;
          n.run     = 1'b0;
          n.st      = i2cm_pkg::I2CM_TX_WAITH;
        end
      end
      i2cm_pkg::I2CM_TX_WAITH: begin
        // Clock stretching: wait for the line to really rise
        if (q.scl_l) begin
          n.cnt = q.reload;
          n.run = 1'b1;
          n.st  = i2cm_pkg::I2CM_TX_HIGH;
        end
      end
      i2cm_pkg::I2CM_TX_HIGH: begin
        if (q.bitn < `I2CM_LAST_BIT && q.shreg[7] && !q.sda_l) begin
          coll = 1'b1; // [R13]
        end else if (tick) begin
          n.drv_scl = 1'b1;
          if (q.bitn == `I2CM_LAST_BIT) begin
            n.ack_stat   = q.sda_l;
            n.event_flag = 1'b1; // [R08]
            n.run        = 1'b0;
            n.st         = i2cm_pkg::I2CM_IDLE;
          end else begin
            if (q.bitn == 4'h7) n.buf_full = 1'b0;
            n.shreg = {q.shreg[6:0], 1'b0};
            n.bitn  = q.bitn + 4'h1;
            n.cnt   = q.reload;
            n.st    = i2cm_pkg::I2CM_TX_LOW;
          end
        end
      end
      // Acknowledge: low half, then high half with arbitration
      i2cm_pkg::I2CM_AK_A: begin
        if (tick) begin
          n.drv_scl = 1'b0; // [R03]
          n.run     = 1'b0;
          n.st      = i2cm_pkg::I2CM_AK_B;
        end
      end
      i2cm_pkg::I2CM_AK_B: begin
        if (q.scl_l) begin
          n.cnt = q.reload; // [R03]
          n.run = 1'b1;
          n.st  = i2cm_pkg::I2CM_AK_C;
        end
      end
      i2cm_pkg::I2CM_AK_C: begin
        if (q.ack_data && !q.sda_l) begin
          coll = 1'b1; // [R15]
        end else if (tick) begin
          n.drv_scl = 1'b1; // [R03]
          n.ack_en  = 1'b0;
          n.run     = 1'b0;
          n.st      = i2cm_pkg::I2CM_IDLE;
        end
      end
      // Stop: data low, clock released, then data released
      i2cm_pkg::I2CM_SP_A: begin
        if (!q.sda_l) begin
          n.cnt = q.reload; // [R05]
          n.run = 1'b1;
          n.st  = i2cm_pkg::I2CM_SP_B;
        end
      end
      i2cm_pkg::I2CM_SP_B: begin
        if (tick) begin
          n.drv_scl = 1'b0; // [R05]
          n.cnt     = q.reload;
          n.st      = i2cm_pkg::I2CM_SP_C;
        end
      end
      i2cm_pkg::I2CM_SP_C: begin
        if (tick) begin
          n.drv_sda = 1'b0; // [R05]
          n.run     = 1'b0;
          n.st      = i2cm_pkg::I2CM_SP_D;
        end
      end
      i2cm_pkg::I2CM_SP_D: begin
        if (q.sda_l && q.scl_l) begin
          n.stop_seen = 1'b1; // [R06]
          n.cnt       = q.reload;
          n.run       = 1'b1;
          n.st        = i2cm_pkg::I2CM_SP_E;
        end
      end
      i2cm_pkg::I2CM_SP_E: begin
        if (tick) begin
          n.stop_en    = 1'b0; // [R06]
          n.event_flag = 1'b1; // [R06]
          n.run        = 1'b0;
          n.st         = i2cm_pkg::I2CM_IDLE;
        end
      end
    endcase

    // Lost arbitration: everything let go, port back to idle
    if (coll) begin
      n.bcol      = 1'b1; // [R13]
      n.drv_scl   = 1'b0; // [R14] [R15]
      n.drv_sda   = 1'b0;
      n.buf_full  = 1'b0; // [R14]
      n.run       = 1'b0;
      n.start_en  = 1'b0; // [R15]
      n.rstart_en = 1'b0;
      n.stop_en   = 1'b0;
      n.ack_en    = 1'b0;
      n.st        = i2cm_pkg::I2CM_IDLE;
    end

    // Disabled port: any transfer ends and start and stop seen flags stay clear
    if (!q.port_en) begin
      n.st         = i2cm_pkg::I2CM_IDLE; // [R09]
      n.drv_scl    = 1'b0;
      n.drv_sda    = 1'b0;
      n.run        = 1'b0;
      n.start_en   = 1'b0;
      n.rstart_en  = 1'b0;
      n.stop_en    = 1'b0;
      n.ack_en     = 1'b0;
      n.start_seen = 1'b0; // [R10]
      n.stop_seen  = 1'b0; // [R10]
    end
  end

  // State register; reset leaves the port disabled
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q        <= '0; // [R09] [R10]
      q.st     <= i2cm_pkg::I2CM_IDLE;
      q.scl_sy <= 3'h7;
      q.sda_sy <= 3'h7;
      q.scl_l  <= 1'b1;
      q.sda_l  <= 1'b1;
      q.reload <= `I2CM_RELOAD_RST;
    end else begin
      q <= n;
    end
  end

endmodule

// File: i2cm_seq_properties.sv
// Port checks of the master sequencer
`timescale 1ns/100ps
`include "i2cm_regs.svh"

module i2cm_seq_properties (
  input wire logic                    ref_clk,
  input wire logic                    srst,
  input wire logic [`I2CM_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]              reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [7:0]              reg_rdata,
  input wire logic                    scl_oe,
  input wire logic                    sda_oe,
  input wire logic                    sleep_mode,
  input wire logic                    wake_req
);
  logic [6:0] rl;
  logic [7:0] low_cnt;
  logic [7:0] high_cnt;
  logic       ack_wr;
  logic       ie;

  // Reload copy, so bit periods are checked against the live setting
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rl <= `I2CM_RELOAD_RST;
    end else if (reg_wr && reg_addr == `I2CM_OFS_RELOAD) begin
      rl <= reg_wdata[6:0];
    end
  end

  // Interrupt enable copy, so wake is checked against software's setting
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ie <= 1'b0;
    end else if (reg_wr && reg_addr == `I2CM_OFS_CTRL) begin
      ie <= reg_wdata[`I2CM_C_INT_EN];
    end
  end

  // Saturating run lengths of clock held low and released
  always_ff @(posedge ref_clk) begin
    if (srst || !scl_oe) begin
      low_cnt <= 8'h00;
    end else if (low_cnt != 8'hFF) begin
      low_cnt <= low_cnt + 8'h01;
    end
    if (srst || scl_oe) begin
      high_cnt <= 8'h00;
    end else if (high_cnt != 8'hFF) begin
      high_cnt <= high_cnt + 8'h01;
    end
  end

  // Acknowledge request written together with the port enable bit
  assign ack_wr = reg_wr && reg_addr == `I2CM_OFS_CTRL
                  && reg_wdata[4] && reg_wdata[0];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_reset_quiet: assert property (
    $fell(srst) |-> !scl_oe && !sda_oe && reg_rdata == 8'h00)
    else $error("Lines or read data active after reset");
  a_read_quiet: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("Read data outside the cycle after a read");
  a_wake_sleep: assert property (
    wake_req |-> sleep_mode && ie)
    else $error("Wake request outside sleep or with interrupt off");
  a_ack_pull: assert property (
    ack_wr && !reg_wdata[5] |-> ##[1:4] (scl_oe && sda_oe))
    else $error("Acknowledge did not pull both lines");
  a_nack_hold: assert property (
    ack_wr && reg_wdata[5] |-> ##[1:4] (scl_oe && !sda_oe))
    else $error("Not-acknowledge did not hold clock only");
  a_clock_low: assert property (
    $fell(scl_oe) && !$past(srst) |-> low_cnt > {1'b0, rl})
    else $error("Clock low shorter than one bit period");
  a_clock_high: assert property (
    $rose(scl_oe) && !$past(srst) |-> high_cnt > {1'b0, rl})
    else $error("Clock high shorter than one bit period");
  a_stop_order: assert property (
    $fell(sda_oe) && !scl_oe && !$fell(scl_oe) |-> high_cnt > {1'b0, rl})
    else $error("Data released too soon after clock");

  // Main scenarios reached
  c_ack: cover property (ack_wr);
  c_stop: cover property ($fell(sda_oe) && !scl_oe);
  c_wake: cover property (wake_req);
endmodule

bind i2cm_seq i2cm_seq_properties u_props (
  .ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .scl_oe, .sda_oe, .sleep_mode, .wake_req
);

// File: i2cm_seq_test.sv
// Register-level tests of the master sequencer
`timescale 1ns/100ps

module i2cm_seq_test;
  logic       ref_clk, srst, reg_wr, reg_rd, sleep_mode, sda_lo;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rx_byte;
  logic       scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe, wake_req;
  int         miscompares, comparisons;

  i2cm_seq dut (
    .ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe,
    .sleep_mode, .wake_req
  );
  i2cm_bus_model bus (
    .scl_oe, .sda_oe, .sda_lo, .scl(scl_in), .sda(sda_in), .rx_byte
  );

  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // Reads until masked bits match, bounded so a hang shows as a mismatch
  task automatic exp_reg(input logic [3:0] a, input logic [7:0] m, w);
    logic [7:0] v;
    v = w ^ m;
    for (int i = 0; i < 200 && (v & m) !== w; i++) begin
      rd(a, v);
    end
    chk($sformatf("reg %h", a), v & m, w);
  endtask

  task automatic chk_lines;
    #1;
    chk("lines", {4'h0, scl_out, sda_out, scl_oe, sda_oe}, 8'h00);
  endtask

  task automatic chk_wake(input logic e);
    #1;
    chk("wake", {7'h00, wake_req}, {7'h00, e});
  endtask

  task automatic tend(input string nm);
    $display("Test %s done", nm);
  endtask

  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog; the tests need a few hundred cycles
  initial begin
    cyc(20000);
    miscompares++;
    finish_test;
  end

  // Test sequence
  initial begin
    {srst, reg_wr, reg_rd, sleep_mode, sda_lo} = 5'h10;
    reg_addr    = 4'h0;
    reg_wdata   = 8'h00;
    miscompares = 0;
    comparisons = 0;
    cyc(10);
    srst <= 1'b0;
    cyc(6);
    exp_reg(4'h0, 8'hFF, 8'h00);
    exp_reg(4'h4, 8'h3F, 8'h00);
    exp_reg(4'h8, 8'hFF, 8'h13);
    exp_reg(4'h1, 8'hFF, 8'h00);
    wr(4'h0, 8'h01);
    wr(4'h8, 8'h04);
    tend("reset");
    // Another master: start then stop, eight cycles apart
    sda_lo <= 1'b1;
    cyc(8);
    sda_lo <= 1'b0;
    exp_reg(4'h4, 8'h28, 8'h28);
    wr(4'h0, 8'h00);
    exp_reg(4'h4, 8'h30, 8'h00);
    wr(4'h0, 8'h01);
    wr(4'h4, 8'h3E);
    tend("monitor");
    // Start with data held low by another party
    sda_lo <= 1'b1;
    cyc(8);
    wr(4'h0, 8'h03);
    exp_reg(4'h4, 8'h04, 8'h04);
    exp_reg(4'h0, 8'h1E, 8'h00);
    chk_lines;
    sda_lo <= 1'b0;
    cyc(8);
    wr(4'h4, 8'h3E);
    tend("start collision");
    // Start, then arbitration lost on the first data bit
    wr(4'h0, 8'h03);
    exp_reg(4'h0, 8'h02, 8'h00);
    exp_reg(4'h4, 8'h18, 8'h18);
    wr(4'h4, 8'h3E);
    wr(4'hC, 8'h80);
    sda_lo <= 1'b1;
    exp_reg(4'h4, 8'h05, 8'h04);
    chk_lines;
    sda_lo <= 1'b0;
    cyc(8);
    wr(4'h4, 8'h3E);
    wr(4'hC, 8'hA5);
    exp_reg(4'h4, 8'h08, 8'h08);
    chk("received byte", rx_byte, 8'hA5);
    exp_reg(4'h4, 8'h81, 8'h00);
    tend("transmit collision");
    // Acknowledge, then not-acknowledge, with a buffer write inside
    wr(4'h0, 8'h11);
    wr(4'hC, 8'h3C);
    exp_reg(4'h0, 8'h10, 8'h00);
    exp_reg(4'h4, 8'h02, 8'h02);
    exp_reg(4'hC, 8'hFF, 8'hA5);
    wr(4'h0, 8'h31);
    exp_reg(4'h0, 8'h10, 8'h00);
    tend("acknowledge");
    // Stop with a buffer write inside
    wr(4'h4, 8'h3E);
    wr(4'h0, 8'h09);
    wr(4'hC, 8'h5A);
    exp_reg(4'h0, 8'h08, 8'h00);
    exp_reg(4'h4, 8'h2A, 8'h2A);
    exp_reg(4'hC, 8'hFF, 8'hA5);
    tend("stop");
    // Not-acknowledge overridden by another party
    wr(4'h4, 8'h3E);
    sda_lo <= 1'b1;
    wr(4'h0, 8'h31);
    exp_reg(4'h4, 8'h04, 8'h04);
    exp_reg(4'h0, 8'h10, 8'h00);
    chk_lines;
    sda_lo <= 1'b0;
    cyc(8);
    tend("acknowledge collision");
    // Repeated start, then stop
    wr(4'h4, 8'h3E);
    wr(4'h0, 8'h05);
    exp_reg(4'h0, 8'h04, 8'h00);
    exp_reg(4'h4, 8'h18, 8'h18);
    wr(4'h0, 8'h09);
    exp_reg(4'h0, 8'h08, 8'h00);
    tend("repeated start");
    // Wake follows the event flag while asleep
    sleep_mode <= 1'b1;
    wr(4'h0, 8'h41);
    chk_wake(1'b1);
    wr(4'h4, 8'h08);
    chk_wake(1'b0);
    sleep_mode <= 1'b0;
    tend("sleep");
    // Reset in the middle of an acknowledge
    wr(4'h0, 8'h11);
    cyc(3);
    srst <= 1'b1;
    cyc(2);
    srst <= 1'b0;
    chk_lines;
    exp_reg(4'h0, 8'hFF, 8'h00);
    tend("reset in transfer");
    finish_test;
  end
endmodule
